// ==== hw/ibsr_pkg.sv ====
package ibsr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STB = 8'h04;
  localparam logic [7:0] REG_TX = 8'h08;
  localparam logic [7:0] REG_RX = 8'h0C;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [7:0] REG_CMD = 8'h14;

  localparam int CTRL_PON_BIT = 5;
  localparam int TX_EOI_BIT = 8;
  localparam int CMD_CLEAR_BIT = 0;
  localparam int FLAGS_RANGE_BIT = 6;
  localparam int RQS_BIT = 6;

  // ****************************************
  // Address limits
  // ****************************************
  localparam logic [4:0] MAX_ADDR = 5'h1E;
  localparam logic [4:0] PP_DEFAULT_MAX = 5'h07;

  // ****************************************
  // Bus command bytes, low seven bits
  // ****************************************
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_PPC = 7'h05;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_PPU = 7'h15;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECONDARY = 2'h3;
  localparam logic [2:0] GRP_PPE = 3'h6;
  localparam logic [2:0] GRP_PPD = 3'h7;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    AH_READY = 2'b01,
    AH_DONE = 2'b10
  } ibsr_ah_t;

  typedef enum logic [2:0] {
    SH_IDLE = 3'b001,
    SH_WAIT_RFD = 3'b010,
    SH_WAIT_ACC = 3'b100
  } ibsr_sh_t;

  // Bus lines seen by the device, 1 = line asserted
  typedef struct packed {
    logic atn;
    logic ifc;
    logic ren;
    logic eoi;
    logic dav;
    logic nrfd;
    logic ndac;
    logic [7:0] dio;
  } ibsr_bus_in_t;

  // Open-drain style drive, 1 = assert line, oe high while driving
  typedef struct packed {
    logic [7:0] dio_o;
    logic [7:0] dio_oe;
    logic dav_o;
    logic dav_oe;
    logic nrfd_o;
    logic nrfd_oe;
    logic ndac_o;
    logic ndac_oe;
    logic eoi_o;
    logic eoi_oe;
    logic srq_o;
    logic srq_oe;
  } ibsr_bus_out_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ibsr_reg_req_t;

endpackage

// ==== hw/ibsr_port.sv ====
// How it works
// - Handshake source/acceptor, talker, listener, service request, remote/local, poll, clear.
// - Address lamp lit while addressed to listen or to talk.
// - SRQ line asserted while a service request is pending.
// - Output faults, programming error or power-on raise a service request.
// - Completed serial poll withdraws request and lamp, cause notwithstanding.
// - Supply clear command also withdraws a pending request.
// - In remote, panel setting changes refused; return-to-local key still works unless locked out.
// - While remote and busy accepting, panel local attempt refused.
// - Local lockout comes only from bus; then panel programming blocked.
// - Local/remote transitions never touch programmed settings.
// - Parallel poll bit follows the request bit, status bit 6.
// - Parallel poll leaves the request bit alone.
// - Unconfigured, address 0..7 answers 1 on data line address+1.
// - Unconfigured, address 8 or above gives no parallel poll answer.
// - Controller may configure any line and sense for the answer.
// - Serial poll drives the eight-bit status byte on the data lines.
// - Addressed and unaddressed device clear act as supply clear.
// - Addresses 0..30 accepted; others written flag a range error, others loaded from storage become 30.
// - Power-on request, if enabled, raised at power-up or power restore.
// - Address and power-on enable kept in non-volatile storage.
module ibsr_port
  import ibsr_pkg::*;
#(
  parameter int N_OUTPUTS = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ibsr_bus_in_t bus_in,
  output ibsr_bus_out_t bus_out,
  input wire ibsr_reg_req_t reg_req,
  output logic [15:0] rd_data,
  input wire logic [N_OUTPUTS-1:0] fault_evt,
  input wire logic prog_error,
  input wire logic power_restore,
  input wire logic return_to_local_key,
  input wire logic panel_change_req,
  output logic panel_change_ok,
  input wire logic [4:0] nv_load_addr,
  input wire logic nv_load_pon,
  output logic nv_store,
  output logic [4:0] nv_store_addr,
  output logic nv_store_pon,
  output logic device_clear,
  output logic addr_lamp,
  output logic srq_lamp,
  output logic remote_lamp
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic loaded;
    logic [4:0] addr;
    logic power_on_request_enable;
    logic listen;
    logic talk;
    logic spmode;
    logic remote;
    logic lockout;
    logic rqs;
    logic [6:0] stb_cause;
    logic pp_pending;
    logic pp_cfg;
    logic pp_en;
    logic pp_sense;
    logic [2:0] pp_line;
    ibsr_ah_t ah;
    ibsr_sh_t sh;
    logic [7:0] rx_data;
    logic rx_full;
    logic [7:0] tx_data;
    logic tx_eoi;
    logic tx_full;
    logic [7:0] sh_byte;
    logic sh_eoi;
    logic sh_poll;
    logic range_err;
    logic clr_pulse;
    logic nv_pulse;
    logic [15:0] rd_data;
  } ibsr_state_t;

  ibsr_state_t s;
  ibsr_state_t next_s;

  logic [7:0] stb;
  logic participate;
  logic nrfd_hold;
  logic pp_active;
  logic pp_enable;
  logic pp_sense;
  logic [2:0] pp_line;
  logic [7:0] pp_mask;

  assign stb = {s.stb_cause[6], s.rqs, s.stb_cause[5:0]};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [6:0] cmd;
    logic withdraw;
    logic raise;
    logic accepted;
    logic clear_cmd;
    cmd = bus_in.dio[6:0];
    withdraw = 1'b0;
    raise = 1'b0;
    accepted = 1'b0;
    clear_cmd = 1'b0;
    next_s = s;
    next_s.clr_pulse = 1'b0;
    next_s.nv_pulse = 1'b0;
    next_s.rd_data = '0;

    // Straps are caught on the first clocked cycle after reset release
    if (!s.loaded) begin
      next_s.loaded = 1'b1;
      next_s.addr = (nv_load_addr > MAX_ADDR) ? MAX_ADDR : nv_load_addr;
      next_s.power_on_request_enable = nv_load_pon;
      raise = nv_load_pon;
    end
    if (power_restore && s.power_on_request_enable) begin
      raise = 1'b1;
    end
    if ((|fault_evt) || prog_error) begin
      raise = 1'b1;
    end

    // Acceptor handshake
    unique case (s.ah)
      AH_READY: begin
        if (participate && !nrfd_hold && bus_in.dav) begin
          accepted = 1'b1;
          next_s.ah = AH_DONE;
        end
      end
      AH_DONE: begin
        if (!bus_in.dav) begin
          next_s.ah = AH_READY;
        end
      end
    endcase

    if (accepted && bus_in.atn) begin
      if (cmd[6:5] != GRP_SECONDARY) begin
        next_s.pp_pending = 1'b0;
      end
      if (cmd == {GRP_LISTEN, s.addr}) begin
        next_s.listen = 1'b1;
        if (bus_in.ren) begin
          next_s.remote = 1'b1;
        end
      end else if (cmd == CMD_UNL) begin
        next_s.listen = 1'b0;
      end
      if (cmd == {GRP_TALK, s.addr}) begin
        next_s.talk = 1'b1;
      end else if (cmd[6:5] == GRP_TALK) begin
        next_s.talk = 1'b0;
      end
      if (cmd == CMD_SPE) begin
        next_s.spmode = 1'b1;
      end
      if (cmd == CMD_SPD) begin
        next_s.spmode = 1'b0;
      end
      if (cmd == CMD_DCL || (cmd == CMD_SDC && s.listen)) begin
        clear_cmd = 1'b1;
      end
      if (cmd == CMD_LLO) begin
        next_s.lockout = 1'b1;
      end
      if (cmd == CMD_GTL && s.listen) begin
        next_s.remote = 1'b0;
      end
      if (cmd == CMD_PPC && s.listen) begin
        next_s.pp_pending = 1'b1;
      end
      if (cmd == CMD_PPU) begin
        next_s.pp_cfg = 1'b0;
      end
      if (s.pp_pending && cmd[6:4] == GRP_PPE) begin
        next_s.pp_cfg = 1'b1;
        next_s.pp_en = 1'b1;
        next_s.pp_sense = cmd[3];
        next_s.pp_line = cmd[2:0];
      end
      if (s.pp_pending && cmd[6:4] == GRP_PPD) begin
        next_s.pp_cfg = 1'b1;
        next_s.pp_en = 1'b0;
      end
    end else if (accepted && s.listen) begin
      next_s.rx_data = bus_in.dio;
      next_s.rx_full = 1'b1;
    end

    // Source handshake; data byte or, in serial poll, the status byte
    unique case (s.sh)
      SH_IDLE: begin
        if (s.talk && !bus_in.atn && (s.spmode || s.tx_full)) begin
          next_s.sh_byte = s.spmode ? stb : s.tx_data;
          next_s.sh_eoi = !s.spmode && s.tx_eoi;
          next_s.sh_poll = s.spmode;
          next_s.sh = SH_WAIT_RFD;
        end
      end
      SH_WAIT_RFD: begin
        if (bus_in.atn) begin
          next_s.sh = SH_IDLE;
        end else if (!bus_in.nrfd) begin
          next_s.sh = SH_WAIT_ACC;
        end
      end
      SH_WAIT_ACC: begin
        if (bus_in.atn) begin
          next_s.sh = SH_IDLE;
        end else if (!bus_in.ndac) begin
          next_s.sh = SH_IDLE;
          if (s.sh_poll) begin
            withdraw = 1'b1;
          end else begin
            next_s.tx_full = 1'b0;
          end
        end
      end
      default: begin
        next_s.sh = SH_IDLE;
      end
    endcase

    // Return-to-local key, unless locked out or mid-transfer
    if (return_to_local_key && !s.lockout) begin
      if (!(s.listen && (s.ah == AH_DONE || s.rx_full))) begin
        next_s.remote = 1'b0;
      end
    end

    // Register port
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        REG_CTRL: begin
          if (reg_req.wdata[4:0] > MAX_ADDR) begin
            next_s.range_err = 1'b1;
          end else begin
            next_s.addr = reg_req.wdata[4:0];
          end
          next_s.power_on_request_enable = reg_req.wdata[CTRL_PON_BIT];
          next_s.nv_pulse = 1'b1;
        end
        REG_STB: begin
          next_s.stb_cause = {reg_req.wdata[7], reg_req.wdata[5:0]};
        end
        REG_TX: begin
          if (!s.tx_full) begin
            next_s.tx_data = reg_req.wdata[7:0];
            next_s.tx_eoi = reg_req.wdata[TX_EOI_BIT];
            next_s.tx_full = 1'b1;
          end
        end
        REG_FLAGS: begin
          if (reg_req.wdata[FLAGS_RANGE_BIT]) begin
            next_s.range_err = 1'b0;
          end
        end
        REG_CMD: begin
          if (reg_req.wdata[CMD_CLEAR_BIT]) begin
            clear_cmd = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        REG_CTRL: next_s.rd_data = {10'h000, s.power_on_request_enable, s.addr};
        REG_STB: next_s.rd_data = {8'h00, stb};
        REG_RX: begin
          next_s.rd_data = {8'h00, s.rx_data};
          // A byte landing in this very cycle is kept for the next read
          next_s.rx_full = next_s.rx_full && !s.rx_full;
        end
        REG_FLAGS: next_s.rd_data = {9'h000, s.range_err, s.tx_full, s.rx_full,
                                      s.lockout, s.remote, s.talk, s.listen};
        default: next_s.rd_data = '0;
      endcase
    end

    if (clear_cmd) begin
      withdraw = 1'b1;
      next_s.clr_pulse = 1'b1;
    end

    // Request flag: a new cause wins over a clear in the same cycle
    if (withdraw) begin
      next_s.rqs = 1'b0;
    end
    if (raise) begin
      next_s.rqs = 1'b1;
    end

    // Dropping remote enable ends remote and lockout; interface clear unaddresses
    if (!bus_in.ren) begin
      next_s.remote = 1'b0;
      next_s.lockout = 1'b0;
    end
    if (bus_in.ifc) begin
      next_s.listen = 1'b0;
      next_s.talk = 1'b0;
      next_s.spmode = 1'b0;
      next_s.pp_pending = 1'b0;
      next_s.sh = SH_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '{ah: AH_READY, sh: SH_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Bus drive
  // ****************************************
  assign participate = (bus_in.atn || s.listen) && s.loaded;
  // Data bytes are held off while software has not read the last one
  assign nrfd_hold = !bus_in.atn && s.rx_full;

  // Parallel poll: identify with ATN and EOI together
  assign pp_active = bus_in.atn && bus_in.eoi;
  assign pp_enable = s.pp_cfg ? s.pp_en : (s.addr <= PP_DEFAULT_MAX);
  assign pp_sense = s.pp_cfg ? s.pp_sense : 1'b1;
  assign pp_line = s.pp_cfg ? s.pp_line : s.addr[2:0];

  // Only reads the request bit, never changes it
  generate
    for (genvar i = 0; i < 8; i++) begin : g_pp
      assign pp_mask[i] = pp_active && pp_enable && (pp_line == 3'(i))
                          && (s.rqs == pp_sense);
    end
  endgenerate

  always_comb begin
    bus_out = '0;
    if (s.sh != SH_IDLE) begin
      bus_out.dio_o = s.sh_byte;
      bus_out.dio_oe = 8'hFF;
      bus_out.eoi_o = s.sh_eoi;
      bus_out.eoi_oe = s.sh_eoi;
    end else if (pp_active) begin
      bus_out.dio_o = pp_mask;
      bus_out.dio_oe = pp_mask;
    end
    bus_out.dav_o = (s.sh == SH_WAIT_ACC);
    bus_out.dav_oe = (s.sh == SH_WAIT_ACC);
    bus_out.nrfd_o = participate && (s.ah == AH_DONE || nrfd_hold);
    bus_out.nrfd_oe = bus_out.nrfd_o;
    bus_out.ndac_o = participate && (s.ah == AH_READY);
    bus_out.ndac_oe = bus_out.ndac_o;
    bus_out.srq_o = s.rqs;
    bus_out.srq_oe = s.rqs;
  end

  // ****************************************
  // Front panel and side outputs
  // ****************************************
  assign panel_change_ok = panel_change_req && !s.remote && !s.lockout;
  assign addr_lamp = s.listen || s.talk;
  assign srq_lamp = s.rqs;
  assign remote_lamp = s.remote;
  assign device_clear = s.clr_pulse;
  assign nv_store = s.nv_pulse;
  assign nv_store_addr = s.addr;
  assign nv_store_pon = s.power_on_request_enable;
  assign rd_data = s.rd_data;

endmodule

// ==== test/ibsr_port_monitor.sv ====
module ibsr_port_monitor
  import ibsr_pkg::*;
#(
  parameter int N_OUTPUTS = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire ibsr_bus_in_t bus_in,
  input wire ibsr_bus_out_t bus_out,
  input wire ibsr_reg_req_t reg_req,
  input wire logic [N_OUTPUTS-1:0] fault_evt,
  input wire logic prog_error,
  input wire logic power_restore,
  input wire logic panel_change_ok,
  input wire logic device_clear,
  input wire logic srq_lamp,
  input wire logic remote_lamp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic clr_wr;
  logic any_evt;
  assign clr_wr = reg_req.wr && reg_req.addr == REG_CMD && reg_req.wdata[CMD_CLEAR_BIT];
  assign any_evt = |fault_evt || prog_error || power_restore;

  // ******
  // Handshake steps
  // ******
  sequence src_acked;
    bus_out.dav_o && !bus_in.ndac;
  endsequence
  sequence acc_offer;
    bus_out.ndac_o && !bus_out.nrfd_o && bus_in.dav && bus_in.atn;
  endsequence

  srq_line_a: assert property (
    bus_out.srq_o == srq_lamp && bus_out.srq_oe == srq_lamp)
    else $error("srq line mismatch");
  fault_raise_a: assert property (|fault_evt || prog_error |-> ##[1:2] srq_lamp)
    else $error("request not raised");
  clr_pulse_a: assert property (clr_wr |=> device_clear)
    else $error("no clear pulse");
  clr_drop_a: assert property (clr_wr && !any_evt |-> ##[1:2] !srq_lamp)
    else $error("request not withdrawn");
  clr_single_a: assert property (device_clear |=> !device_clear)
    else $error("clear pulse too long");
  pp_keep_a: assert property (
    bus_in.atn && bus_in.eoi && srq_lamp && !clr_wr |=> srq_lamp)
    else $error("poll cleared request");
  pp_one_a: assert property (bus_in.atn && bus_in.eoi |-> $onehot0(bus_out.dio_oe))
    else $error("poll drives several lines");
  atn_quiet_a: assert property (
    bus_in.atn && $past(bus_in.atn) && !bus_in.eoi |-> bus_out.dio_oe == 8'h00)
    else $error("data driven under command");
  dav_ready_a: assert property ($rose(bus_out.dav_o) |-> !$past(bus_in.nrfd))
    else $error("valid before ready");
  dav_drop_a: assert property (src_acked |=> !bus_out.dav_o)
    else $error("valid held after accept");
  acc_step_a: assert property (acc_offer |=> bus_out.nrfd_o && !bus_out.ndac_o)
    else $error("byte not accepted");
  panel_block_a: assert property (
    remote_lamp ##1 remote_lamp |-> !$past(panel_change_ok))
    else $error("panel change in remote");
  ren_local_a: assert property ((!bus_in.ren) [*2] |=> !remote_lamp)
    else $error("remote without enable");
endmodule

bind ibsr_port ibsr_port_monitor #(.N_OUTPUTS(N_OUTPUTS)) i_mon (
  .clk, .sys_rst, .bus_in, .bus_out, .reg_req, .fault_evt, .prog_error,
  .power_restore, .panel_change_ok, .device_clear, .srq_lamp, .remote_lamp
);

// ==== test/ibsr_ctl_model.sv ====
module ibsr_ctl_model
  import ibsr_pkg::*;
(
  input wire logic clk,
  input wire ibsr_bus_in_t bus,
  output ibsr_bus_in_t drv
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  // Handshake waits that ran out; the bench compares this against zero
  int stalls = 0;
  initial drv = '0;

  // ******
  // Source side
  // ******
  // Lockout and poll setup are only ever sent from here
  task automatic send(input logic a, input logic [7:0] b, input int slow);
    @(posedge clk);
    drv.nrfd <= 1'b0;
    drv.ndac <= 1'b0;
    n = 0;
    do @(posedge clk); while (bus.nrfd && n++ < 60);
    if (n > 60) stalls++;
    repeat (slow) @(posedge clk);
    drv.atn <= a;
    drv.dio <= b;
    drv.dav <= 1'b1;
    n = 0;
    do @(posedge clk); while (bus.ndac && n++ < 60);
    if (n > 60) stalls++;
    drv.dav <= 1'b0;
    drv.dio <= 8'h00;
  endtask

  // ******
  // Acceptor side
  // ******
  // Ends with command mode back on, so the talker is cut off cleanly
  task automatic take(output logic [7:0] b, input int slow);
    @(posedge clk);
    drv.atn <= 1'b0;
    drv.ndac <= 1'b1;
    drv.nrfd <= 1'b1;
    repeat (slow + 1) @(posedge clk);
    drv.nrfd <= 1'b0;
    n = 0;
    do @(posedge clk); while (!bus.dav && n++ < 60);
    if (n > 60) stalls++;
    b = bus.dio;
    drv.nrfd <= 1'b1;
    drv.ndac <= 1'b0;
    n = 0;
    do @(posedge clk); while (bus.dav && n++ < 60);
    if (n > 60) stalls++;
    drv.ndac <= 1'b1;
    drv.atn <= 1'b1;
  endtask

  task automatic ppoll(output logic [7:0] b);
    @(posedge clk);
    drv.atn <= 1'b1;
    drv.eoi <= 1'b1;
    @(posedge clk);
    b = bus.dio;
    drv.eoi <= 1'b0;
  endtask
endmodule

// ==== test/tb.sv ====
module tb
  import ibsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, prog_error, power_restore, return_to_local_key;
  logic panel_change_req, panel_change_ok, nv_load_pon, nv_store, nv_store_pon;
  logic device_clear, addr_lamp, srq_lamp, remote_lamp;
  ibsr_bus_in_t bus_in, drv;
  ibsr_bus_out_t bus_out;
  ibsr_reg_req_t reg_req;
  logic [15:0] rd_data, v, w;
  logic [3:0] fault_evt, pp;
  logic [4:0] nv_load_addr, nv_store_addr, adr;
  logic [7:0] b;
  int err_total, checked, k;

  // Wired lines: asserted if any party asserts them
  assign bus_in = drv | ibsr_bus_in_t'({3'b000, bus_out.eoi_o & bus_out.eoi_oe,
    bus_out.dav_o & bus_out.dav_oe, bus_out.nrfd_o & bus_out.nrfd_oe,
    bus_out.ndac_o & bus_out.ndac_oe, bus_out.dio_o & bus_out.dio_oe});

  ibsr_port #(.N_OUTPUTS(4)) i_ibsr_port (.clk, .sys_rst, .bus_in, .bus_out, .reg_req,
    .rd_data, .fault_evt, .prog_error, .power_restore, .return_to_local_key,
    .panel_change_req, .panel_change_ok, .nv_load_addr, .nv_load_pon, .nv_store,
    .nv_store_addr, .nv_store_pon, .device_clear, .addr_lamp, .srq_lamp, .remote_lamp);
  ibsr_ctl_model i_ctl (.clk, .bus(bus_in), .drv);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ******
  // Tasks
  // ******
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    reg_req <= '0;
    #1 d = rd_data;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Index 0..3 fault, 4 prog error, 5 power restore, 6 local key
  task automatic ev(input int i);
    @(posedge clk);
    {return_to_local_key, power_restore, prog_error, fault_evt} <= 7'h01 << i;
    @(posedge clk);
    {return_to_local_key, power_restore, prog_error, fault_evt} <= 7'h00;
  endtask
  task automatic cmd(input logic [7:0] c);
    i_ctl.send(1'b1, c, $urandom_range(0, 3));
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    close_out();
  end

  // ******
  // Main sequence
  // ******
  initial begin
    err_total = 0;
    checked = 0;
    v = 16'($urandom(75005));
    sys_rst = 1'b1;
    reg_req = '0;
    {return_to_local_key, power_restore, prog_error, fault_evt} = 7'h00;
    panel_change_req = 1'b0;
    adr = 5'($urandom_range(0, 7));
    nv_load_addr = adr;
    nv_load_pon = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    tick(3);
    chk("pon srq", 16'h0001, 16'(bus_out.srq_o));
    rd(REG_CTRL, v);
    chk("nv ctrl", {10'h000, 1'b1, adr}, v);
    rd(REG_STB, v);
    chk("rqs bit", 16'h0001, 16'(v[RQS_BIT]));
    i_ctl.ppoll(b);
    chk("pp default", 16'h0001 << adr, 16'(b));
    tick(1);
    chk("pp keeps rqs", 16'h0001, 16'(srq_lamp));
    @(posedge clk);
    i_ctl.drv.ren <= 1'b1;
    panel_change_req <= 1'b1;
    cmd({1'b0, GRP_LISTEN, adr});
    tick(1);
    chk("listen lamp", 16'h0001, 16'(addr_lamp));
    chk("panel remote", 16'h0000, 16'(panel_change_ok));
    ev(6);
    tick(2);
    chk("local key", 16'h0001, 16'(panel_change_ok));
    cmd({1'b0, GRP_LISTEN, adr});
    v = 16'($urandom_range(0, 255));
    i_ctl.send(1'b0, v[7:0], 1);
    ev(6);
    tick(2);
    chk("key refused", 16'h0000, 16'(panel_change_ok));
    chk("stays remote", 16'h0001, 16'(remote_lamp));
    rd(REG_RX, w);
    chk("rx byte", {8'h00, v[7:0]}, w);
    cmd({1'b0, CMD_LLO});
    cmd({1'b0, CMD_GTL});
    tick(2);
    chk("lockout", 16'h0000, 16'(panel_change_ok));
    @(posedge clk);
    i_ctl.drv.ren <= 1'b0;
    tick(3);
    chk("ren off", 16'h0001, 16'(panel_change_ok));
    rd(REG_CTRL, w);
    chk("ctrl kept", {10'h000, 1'b1, adr}, w);
    cmd({1'b0, CMD_UNL});
    cmd({1'b0, CMD_SPE});
    cmd({1'b0, GRP_TALK, adr});
    tick(1);
    chk("talk lamp", 16'h0001, 16'(addr_lamp));
    i_ctl.take(b, $urandom_range(0, 4));
    tick(2);
    chk("status rqs", 16'h0001, 16'(b[RQS_BIT]));
    chk("poll clears", 16'h0000, {15'h0000, srq_lamp | bus_out.srq_o});
    cmd({1'b0, CMD_SPD});
    w = 16'($urandom_range(0, 255));
    wr(REG_TX, {7'h00, 1'b1, w[7:0]});
    i_ctl.take(b, 1);
    chk("tx byte", {8'h00, w[7:0]}, {8'h00, b});
    cmd({1'b0, CMD_UNT});
    for (k = 0; k < 6; k++) begin
      ev(k);
      tick(2);
      chk("srq raised", 16'h0001, 16'(srq_lamp));
      case (k % 3)
        0: wr(REG_CMD, 16'h0001);
        1: cmd({1'b0, CMD_DCL});
        default: begin
          cmd({1'b0, GRP_LISTEN, adr});
          cmd({1'b0, CMD_SDC});
          cmd({1'b0, CMD_UNL});
        end
      endcase
      tick(2);
      chk("srq withdrawn", 16'h0000, 16'(srq_lamp));
    end
    wr(REG_CTRL, 16'h003F);
    rd(REG_FLAGS, w);
    chk("range flag", 16'h0001, 16'(w[FLAGS_RANGE_BIT]));
    rd(REG_CTRL, w);
    chk("addr kept", {11'h000, adr}, {11'h000, w[4:0]});
    wr(REG_STB, 16'h00FF);
    rd(REG_STB, w);
    chk("stb cause", 16'h00BF, w);
    adr = 5'($urandom_range(8, 30));
    wr(REG_CTRL, {10'h000, 1'b1, adr});
    #1;
    chk("nv store", 16'({2'h3, adr}), 16'({nv_store, nv_store_pon, nv_store_addr}));
    ev(4);
    tick(2);
    i_ctl.ppoll(b);
    chk("pp high addr", 16'h0000, 16'(b));
    cmd({1'b0, GRP_LISTEN, adr});
    cmd({1'b0, CMD_PPC});
    pp = 4'($urandom_range(0, 15));
    cmd({1'b0, GRP_PPE, pp});
    for (k = 1; k >= 0; k--) begin
      i_ctl.ppoll(b);
      chk("pp set", (pp[3] == k[0]) ? 16'h0001 << pp[2:0] : 16'h0000, 16'(b));
      wr(REG_CMD, 16'h0001);
      tick(2);
    end
    chk("listen kept", 16'h0001, 16'(addr_lamp));
    @(posedge clk);
    i_ctl.drv.ifc <= 1'b1;
    @(posedge clk);
    i_ctl.drv.ifc <= 1'b0;
    tick(1);
    chk("ifc clears", 16'h0000, 16'(addr_lamp));
    chk("handshake stalls", 16'h0000, 16'(i_ctl.stalls));
    close_out();
  end
endmodule
